//--- logic/bcd_cpu_end.sv
/*
 * Processor end: issues one command code per cycle from a user request,
 * drives its own data (zero on the call-clear code) and returns bus data.
 * Assumes a device end on the same link and clock.
 */
`timescale 1ns/100ps
`include "bcd_defines.svh"
module bcd_cpu_end (
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	bcd_link_if.cpu                link,
	input  wire logic              req_valid,
	input  wire bcd_pkg::bcd_cmd_t req_cmd,
	input  wire bcd_pkg::bcd_byte_t req_data,
	input  wire logic              req_drive,
	output logic                   rsp_valid,
	output bcd_pkg::bcd_byte_t     rsp_data,
	output logic                   irq_seen
);
	import bcd_pkg::*;

	// ====================================================================
	// Command phase then data phase
	bcd_cmd_t  cmd_ff;
	logic      valid_ff;
	logic      drv_ff;
	bcd_byte_t hold_ff;
	bcd_byte_t data_ff;
	logic      oe_n_ff;
	logic      vd_ff;
	bcd_byte_t rsp_ff;
	logic      rsp_v_ff;

	wire logic is_clear = req_cmd == `BCD_CMD_CALLZ;                     // [RULE_08]
	wire logic nxt_drv  = req_valid && (req_drive || is_clear);
	wire bcd_byte_t nxt_data = is_clear ? `BCD_ZERO8 : req_data;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_ff   <= `BCD_CMD_FETCH;
			valid_ff <= 1'b0;
			drv_ff   <= 1'b0;
			hold_ff  <= `BCD_ZERO8;
			data_ff  <= `BCD_ZERO8;
			oe_n_ff  <= 1'b1;
			vd_ff    <= 1'b0;
			rsp_ff   <= `BCD_ZERO8;
			rsp_v_ff <= 1'b0;
		end else begin
			cmd_ff   <= req_cmd;                                         // [RULE_23]
			valid_ff <= req_valid;
			drv_ff   <= nxt_drv;
			hold_ff  <= nxt_data;
			// Own data goes out in the data phase, when devices sample the bus
			data_ff  <= hold_ff;
			oe_n_ff  <= !drv_ff;
			vd_ff    <= valid_ff;
			rsp_v_ff <= vd_ff;
			rsp_ff   <= link.bus_data;
		end
	end

	assign link.bus_command_code = cmd_ff;
	assign link.cmd_valid        = valid_ff;
	assign link.cpu_data         = data_ff;
	assign link.cpu_oe_n         = oe_n_ff;
	assign rsp_valid             = rsp_v_ff;
	assign rsp_data              = rsp_ff;
	assign irq_seen              = link.int_req;
endmodule : bcd_cpu_end

//--- logic/bcd_defines.svh
/*
 * Command codes, widths and reset values for the bus command link.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef BCD_DEFINES_SVH
`define BCD_DEFINES_SVH

`define BCD_CMD_W        5
`define BCD_DATA_W       8
`define BCD_ADDR_W       16
`define BCD_CMD_FETCH    5'h00
`define BCD_CMD_BRANCH   5'h01
`define BCD_CMD_DREAD    5'h02
`define BCD_CMD_IMM      5'h03
`define BCD_CMD_RET      5'h04
`define BCD_CMD_DWRITE   5'h05
`define BCD_CMD_DC_HI    5'h06
`define BCD_CMD_SR_HI    5'h07
`define BCD_CMD_CALLZ    5'h08
`define BCD_CMD_DC_LO    5'h09
`define BCD_CMD_DC_ADD   5'h0A
`define BCD_CMD_SR_LO    5'h0B
`define BCD_CMD_PCL_MEM  5'h0C
`define BCD_CMD_SR_INC   5'h0D
`define BCD_CMD_DCL_MEM  5'h0E
`define BCD_CMD_VEC_LO   5'h0F
`define BCD_CMD_INHIBIT  5'h10
`define BCD_CMD_DCH_MEM  5'h11
`define BCD_CMD_CALL_BUS 5'h12
`define BCD_CMD_VEC_HI   5'h13
`define BCD_CMD_PCH_BUS  5'h14
`define BCD_CMD_SRH_BUS  5'h15
`define BCD_ZERO16       16'h0000
`define BCD_ONE16        16'h0001
`define BCD_ZERO8        8'h00
`define BCD_MEM_DEPTH    256
`define BCD_MEM_AW       8
`define BCD_BASE_RST     8'h00
`define BCD_VEC_RST      16'h0000

`endif

//--- logic/bcd_device.sv
/*
 * Memory/peripheral end: keeps copies of program_counter, stack_register and
 * data_counter, decodes one command per cycle, owns a 256-byte window and an
 * interrupt vector. Assumes the processor end issues commands on ref_clk.
 */
// Overview of operation
// (RULE_01) Fetch: owner drives opcode, all increment program_counter
// (RULE_02) Branch: owner drives byte, program_counter adds signed
// (RULE_03) Data read: owner drives byte, increment data_counter
// (RULE_04) Operand fetch acts like instruction fetch
// (RULE_05) Return: stack_register copied into program_counter
// (RULE_06) Write bus byte at data_counter, increment
// (RULE_07) Drive data_counter or stack_register high byte
// (RULE_08) Save program_counter, load zero from bus
// (RULE_09) Owner drives data_counter low byte
// (RULE_10) Add signed bus byte to data_counter
// (RULE_11) Owner drives stack_register low byte
// (RULE_12) Memory byte loads program_counter low byte
// (RULE_13) stack_register gets program_counter plus one
// (RULE_14) Memory byte loads data_counter low byte
// (RULE_15) Vector low byte, save program_counter, load low
// (RULE_16) Interrupt logic frozen this cycle
// (RULE_17) Memory byte loads data_counter high byte
// (RULE_18) Save program_counter, bus loads its low byte
// (RULE_19) Vector high byte loads program_counter high
// (RULE_20) Vector high cycle clears pending request
// (RULE_21) Bus byte loads program_counter high byte
// (RULE_22) Bus byte loads stack_register high byte
// (RULE_23) One command per cycle, drive only when owner
`timescale 1ns/100ps
`include "bcd_defines.svh"
module bcd_device (
	input  wire logic           ref_clk,
	input  wire logic           rst_n,
	bcd_link_if.dev             link,
	input  wire bcd_pkg::bcd_byte_t page_base,
	input  wire logic           irq_event,
	output logic                irq_pending,
	output bcd_pkg::bcd_addr_t  pc_copy,
	output bcd_pkg::bcd_addr_t  sr_copy,
	output bcd_pkg::bcd_addr_t  dc_copy
);
	import bcd_pkg::*;

	// ====================================================================
	// Decode helpers
	function automatic logic owns(input bcd_addr_t a, input bcd_byte_t base);
		owns = (a[`BCD_ADDR_W-1:`BCD_MEM_AW] == base);
	endfunction : owns

	function automatic bcd_addr_t sext(input bcd_byte_t b);
		sext = {{(`BCD_ADDR_W-`BCD_DATA_W){b[`BCD_DATA_W-1]}}, b};
	endfunction : sext

	// ====================================================================
	// State
	bcd_addr_t pc_ff, sr_ff, dc_ff;
	bcd_addr_t nxt_pc, nxt_sr, nxt_dc;
	bcd_byte_t mem_ff [`BCD_MEM_DEPTH];
	bcd_byte_t dout_ff;
	logic      oe_n_ff;
	logic      irq_ff;
	logic      irq_s1_ff, irq_s2_ff, irq_s3_ff;
	bcd_addr_t vector_ff;

	wire bcd_cmd_t  cmd      = link.bus_command_code;
	wire logic      act      = link.cmd_valid;               // [RULE_23]
	wire bcd_byte_t bus      = link.bus_data;
	wire logic      own_pc   = owns(pc_ff, page_base);
	wire logic      own_dc   = owns(dc_ff, page_base);
	wire logic      own_sr   = owns(sr_ff, page_base);
	wire bcd_byte_t mem_pc   = mem_ff[pc_ff[`BCD_MEM_AW-1:0]];
	wire bcd_byte_t mem_dc   = mem_ff[dc_ff[`BCD_MEM_AW-1:0]];
	wire logic      wr_mem   = act && cmd == `BCD_CMD_DWRITE && own_dc;  // [RULE_06]
	wire logic      inhibit  = act && cmd == `BCD_CMD_INHIBIT;           // [RULE_16]
	wire logic      ack_hi   = act && cmd == `BCD_CMD_VEC_HI && irq_ff;  // [RULE_20]

	// ====================================================================
	// Bus drive: one cycle after the command, owner only; vector bytes when a request is pending
	logic      nxt_oe;
	bcd_byte_t nxt_dout;
	always_comb begin
		nxt_oe   = 1'b0;
		nxt_dout = `BCD_ZERO8;
		if (act) begin
			case (cmd)
				`BCD_CMD_FETCH, `BCD_CMD_BRANCH, `BCD_CMD_IMM,
				`BCD_CMD_PCL_MEM, `BCD_CMD_DCL_MEM, `BCD_CMD_DCH_MEM: begin
					nxt_oe   = own_pc;                       // [RULE_01] [RULE_02] [RULE_04]
					nxt_dout = mem_pc;                       // [RULE_12] [RULE_14] [RULE_17]
				end
				`BCD_CMD_DREAD: begin
					nxt_oe   = own_dc;                       // [RULE_03]
					nxt_dout = mem_dc;
				end
				`BCD_CMD_DC_HI: begin
					nxt_oe   = own_dc;                       // [RULE_07]
					nxt_dout = dc_ff[`BCD_ADDR_W-1:`BCD_DATA_W];
				end
				`BCD_CMD_SR_HI: begin
					nxt_oe   = own_sr;                       // [RULE_07]
					nxt_dout = sr_ff[`BCD_ADDR_W-1:`BCD_DATA_W];
				end
				`BCD_CMD_DC_LO: begin
					nxt_oe   = own_dc;                       // [RULE_09]
					nxt_dout = dc_ff[`BCD_DATA_W-1:0];
				end
				`BCD_CMD_SR_LO: begin
					nxt_oe   = own_sr;                       // [RULE_11]
					nxt_dout = sr_ff[`BCD_DATA_W-1:0];
				end
				`BCD_CMD_VEC_LO: begin
					nxt_oe   = irq_ff;                       // [RULE_15]
					nxt_dout = vector_ff[`BCD_DATA_W-1:0];
				end
				`BCD_CMD_VEC_HI: begin
					nxt_oe   = irq_ff;                       // [RULE_19]
					nxt_dout = vector_ff[`BCD_ADDR_W-1:`BCD_DATA_W];
				end
				default: begin
					nxt_oe   = 1'b0;
					nxt_dout = `BCD_ZERO8;
				end
			endcase
		end
	end

	// ====================================================================
	// Counter updates, applied in the data phase (one cycle after command)
	bcd_cmd_t cmd_d_ff;
	logic     act_d_ff;
	always_comb begin
		nxt_pc = pc_ff;
		nxt_sr = sr_ff;
		nxt_dc = dc_ff;
		if (act_d_ff) begin
			case (cmd_d_ff)
				`BCD_CMD_FETCH, `BCD_CMD_IMM: nxt_pc = pc_ff + `BCD_ONE16;  // [RULE_01] [RULE_04]
				`BCD_CMD_BRANCH:   nxt_pc = pc_ff + sext(bus);               // [RULE_02]
				`BCD_CMD_DREAD, `BCD_CMD_DWRITE: nxt_dc = dc_ff + `BCD_ONE16; // [RULE_03] [RULE_06]
				`BCD_CMD_RET:      nxt_pc = sr_ff;                           // [RULE_05]
				`BCD_CMD_CALLZ: begin
					nxt_sr = pc_ff;                                          // [RULE_08]
					nxt_pc = {bus, bus};
				end
				`BCD_CMD_DC_ADD:   nxt_dc = dc_ff + sext(bus);               // [RULE_10]
				`BCD_CMD_PCL_MEM:  nxt_pc = {pc_ff[`BCD_ADDR_W-1:`BCD_DATA_W], bus}; // [RULE_12]
				`BCD_CMD_SR_INC:   nxt_sr = pc_ff + `BCD_ONE16;              // [RULE_13]
				`BCD_CMD_DCL_MEM:  nxt_dc = {dc_ff[`BCD_ADDR_W-1:`BCD_DATA_W], bus}; // [RULE_14]
				`BCD_CMD_VEC_LO, `BCD_CMD_CALL_BUS: begin
					nxt_sr = pc_ff;                                          // [RULE_15] [RULE_18]
					nxt_pc = {pc_ff[`BCD_ADDR_W-1:`BCD_DATA_W], bus};
				end
				`BCD_CMD_DCH_MEM:  nxt_dc = {bus, dc_ff[`BCD_DATA_W-1:0]};   // [RULE_17]
				`BCD_CMD_VEC_HI, `BCD_CMD_PCH_BUS:
					nxt_pc = {bus, pc_ff[`BCD_DATA_W-1:0]};                  // [RULE_19] [RULE_21]
				`BCD_CMD_SRH_BUS:  nxt_sr = {bus, sr_ff[`BCD_DATA_W-1:0]};   // [RULE_22]
				default: begin
					nxt_pc = pc_ff;
					nxt_sr = sr_ff;
					nxt_dc = dc_ff;
				end
			endcase
		end
	end

	// Write strobe captured with command, data taken in data phase
	logic wr_d_ff;
	always_ff @(posedge ref_clk) begin
		if (wr_d_ff)
			mem_ff[dc_ff[`BCD_MEM_AW-1:0]] <= bus;                          // [RULE_06]
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pc_ff    <= `BCD_ZERO16;
			sr_ff    <= `BCD_ZERO16;
			dc_ff    <= `BCD_ZERO16;
			cmd_d_ff <= `BCD_CMD_FETCH;
			act_d_ff <= 1'b0;
			wr_d_ff  <= 1'b0;
			oe_n_ff  <= 1'b1;
			dout_ff  <= `BCD_ZERO8;
		end else begin
			pc_ff    <= nxt_pc;
			sr_ff    <= nxt_sr;
			dc_ff    <= nxt_dc;
			cmd_d_ff <= cmd;
			act_d_ff <= act;
			wr_d_ff  <= wr_mem;
			oe_n_ff  <= !nxt_oe;                                         // [RULE_23]
			dout_ff  <= nxt_dout;
		end
	end

	// ====================================================================
	// Interrupt: external event synchronised, request held until acknowledged
	// Edge memory stalls during inhibit, so an edge then is deferred, not lost
	wire logic irq_rise = irq_s2_ff && !irq_s3_ff;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_s1_ff <= 1'b0;
			irq_s2_ff <= 1'b0;
			irq_s3_ff <= 1'b0;
			irq_ff    <= 1'b0;
			vector_ff <= `BCD_VEC_RST;
		end else begin
			irq_s1_ff <= irq_event;
			irq_s2_ff <= irq_s1_ff;
			if (!inhibit) begin                                          // [RULE_16]
				irq_s3_ff <= irq_s2_ff;
				if (irq_rise)
					irq_ff <= 1'b1;
				else if (ack_hi)
					irq_ff <= 1'b0;                                      // [RULE_20]
			end
		end
	end

	assign link.dev_data = dout_ff;
	assign link.dev_oe_n = oe_n_ff;
	assign link.int_req  = irq_ff;
	assign irq_pending   = irq_ff;
	assign pc_copy       = pc_ff;
	assign sr_copy       = sr_ff;
	assign dc_copy       = dc_ff;
endmodule : bcd_device

//--- logic/bcd_link_if.sv
/*
 * Link between processor end and device end: command code, shared data bus
 * and interrupt request. Resolves the bus itself from the two enables.
 */
`timescale 1ns/100ps
`include "bcd_defines.svh"
interface bcd_link_if;
	import bcd_pkg::*;
	bcd_cmd_t  bus_command_code;
	logic      cmd_valid;
	bcd_byte_t cpu_data;
	logic      cpu_oe_n;
	bcd_byte_t dev_data;
	logic      dev_oe_n;
	logic      int_req;
	// Resolved bus level: device wins only when it enables
	bcd_byte_t bus_data;
	assign bus_data = !dev_oe_n ? dev_data : (!cpu_oe_n ? cpu_data : `BCD_ZERO8);

	modport cpu (output bus_command_code, output cmd_valid, output cpu_data,
		output cpu_oe_n, input bus_data, input int_req);
	modport dev (input bus_command_code, input cmd_valid, output dev_data,
		output dev_oe_n, input bus_data, output int_req);
endinterface : bcd_link_if

//--- logic/bcd_pkg.sv
/*
 * Types shared by both ends of the bus command link.
 * Assumes bcd_defines.svh on the include path.
 */
`include "bcd_defines.svh"
package bcd_pkg;
	typedef logic [`BCD_CMD_W-1:0]  bcd_cmd_t;
	typedef logic [`BCD_DATA_W-1:0] bcd_byte_t;
	typedef logic [`BCD_ADDR_W-1:0] bcd_addr_t;
endpackage : bcd_pkg

//--- sim/bcd_link_asserts.sv
/*
 * Checker on the signals of the link between processor and device ends.
 * Assumes instantiation beside the link interface in the testbench top.
 */
`timescale 1ns/100ps
`include "bcd_defines.svh"
module bcd_link_asserts (
	input wire logic              ref_clk,
	input wire logic              rst_n,
	input wire bcd_pkg::bcd_cmd_t bus_command_code,
	input wire logic              cmd_valid,
	input wire bcd_pkg::bcd_byte_t cpu_data,
	input wire logic              cpu_oe_n,
	input wire bcd_pkg::bcd_byte_t dev_data,
	input wire logic              dev_oe_n,
	input wire logic              int_req
);
	import bcd_pkg::*;
	// ==========================================
	// Decoded commands
	wire is_callz = cmd_valid && (bus_command_code == `BCD_CMD_CALLZ);
	wire is_vec   = cmd_valid && ((bus_command_code == `BCD_CMD_VEC_LO) ||
		(bus_command_code == `BCD_CMD_VEC_HI));
	wire is_quiet = cmd_valid && ((bus_command_code == `BCD_CMD_RET) ||
		(bus_command_code == `BCD_CMD_SR_INC) || (bus_command_code == `BCD_CMD_INHIBIT) ||
		(bus_command_code == `BCD_CMD_DWRITE) || (bus_command_code == `BCD_CMD_DC_ADD));

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	// ==========================================
	// Properties
	a_one_bus_driver: assert property (!(!cpu_oe_n && !dev_oe_n))
		else $error("both ends drive the data bus");
	a_dev_after_cmd: assert property (!dev_oe_n |-> $past(cmd_valid))
		else $error("device drives without a command");
	a_cpu_after_cmd: assert property (!cpu_oe_n |-> $past(cmd_valid))
		else $error("processor drives without a command");
	a_callz_zero: assert property (is_callz |=> !cpu_oe_n && cpu_data == `BCD_ZERO8)
		else $error("processor does not drive zero on call-clear");
	a_quiet_dev: assert property (is_quiet |=> dev_oe_n)
		else $error("device drives on a non-read command");
	a_vec_no_irq: assert property (is_vec && !int_req |=> dev_oe_n)
		else $error("vector driven without pending request");
	a_vec_drive: assert property (is_vec && int_req |=> !dev_oe_n && dev_data == 8'h00)
		else $error("vector byte not driven");
	a_irq_clears: assert property (cmd_valid && bus_command_code == `BCD_CMD_VEC_HI && int_req
		|-> ##[1:3] !int_req)
		else $error("request not cleared by vector high");
	a_inhibit_hold: assert property (cmd_valid && bus_command_code == `BCD_CMD_INHIBIT
		|-> ##1 $stable(int_req))
		else $error("interrupt state changed during inhibit");

	c_vec_hi: cover property (cmd_valid && bus_command_code == `BCD_CMD_VEC_HI && int_req);
	c_dev_drive: cover property (!dev_oe_n);
	c_cpu_drive: cover property (!cpu_oe_n);
endmodule : bcd_link_asserts

//--- sim/tb_bus_command_decoder.sv
/*
 * Testbench joining processor end and device end over the link interface.
 * Assumes the design package, defines and interface compiled before it.
 */
`timescale 1ns/100ps
module tb_bus_command_decoder;
	import bcd_pkg::*;
	logic      ref_clk, rst_n, req_valid, req_drive, irq_event;
	logic      rsp_valid, irq_seen, irq_pending;
	bcd_cmd_t  req_cmd;
	bcd_byte_t req_data, rsp_data, page_base;
	bcd_addr_t pc_copy, sr_copy, dc_copy;
	int        fail_count = 0;
	int        n_compared = 0;
	int        cycles = 0;

	bcd_link_if link();
	bcd_cpu_end i_bcd_cpu_end (.ref_clk(ref_clk), .rst_n(rst_n), .link(link),
		.req_valid(req_valid), .req_cmd(req_cmd), .req_data(req_data),
		.req_drive(req_drive), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.irq_seen(irq_seen));
	bcd_device i_bcd_device (.ref_clk(ref_clk), .rst_n(rst_n), .link(link),
		.page_base(page_base), .irq_event(irq_event), .irq_pending(irq_pending),
		.pc_copy(pc_copy), .sr_copy(sr_copy), .dc_copy(dc_copy));
	bcd_link_asserts i_bcd_link_asserts (.ref_clk(ref_clk), .rst_n(rst_n),
		.bus_command_code(link.bus_command_code), .cmd_valid(link.cmd_valid),
		.cpu_data(link.cpu_data), .cpu_oe_n(link.cpu_oe_n), .dev_data(link.dev_data),
		.dev_oe_n(link.dev_oe_n), .int_req(link.int_req));

	// ==========================================
	// Tasks
	task automatic wrap_up;
		if (fail_count == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : wrap_up

	task automatic chk(input bcd_addr_t got, input bcd_addr_t exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// One command, then compare response and all counter copies
	task automatic op(input bcd_cmd_t c, input bcd_byte_t d, input logic dr,
		input bcd_byte_t er, input bcd_addr_t epc, input bcd_addr_t esr, input bcd_addr_t edc);
		@(posedge ref_clk);
		req_valid <= 1'b1;
		req_cmd   <= c;
		req_data  <= d;
		req_drive <= dr;
		@(posedge ref_clk);
		req_valid <= 1'b0;
		req_drive <= 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
		chk({15'h0000, rsp_valid}, 16'h0001);
		chk({8'h00, rsp_data}, {8'h00, er});
		chk(pc_copy, epc);
		chk(sr_copy, esr);
		chk(dc_copy, edc);
	endtask : op

	// ==========================================
	// Clock, timeout, sequence
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 1000) begin
			fail_count++;
			wrap_up();
		end
	end

	initial begin
		rst_n = 1'b0;
		req_valid = 1'b0;
		req_drive = 1'b0;
		req_cmd = 5'h00;
		req_data = 8'h00;
		page_base = 8'h00;
		irq_event = 1'b0;
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		op(5'h05, 8'h03, 1'b1, 8'h03, 16'h0000, 16'h0000, 16'h0001);
		op(5'h05, 8'h80, 1'b1, 8'h80, 16'h0000, 16'h0000, 16'h0002);
		op(5'h05, 8'hFE, 1'b1, 8'hFE, 16'h0000, 16'h0000, 16'h0003);
		op(5'h0A, 8'h02, 1'b1, 8'h02, 16'h0000, 16'h0000, 16'h0005);
		op(5'h05, 8'hA5, 1'b1, 8'hA5, 16'h0000, 16'h0000, 16'h0006);
		op(5'h0A, 8'hFF, 1'b1, 8'hFF, 16'h0000, 16'h0000, 16'h0005);
		op(5'h02, 8'h00, 1'b0, 8'hA5, 16'h0000, 16'h0000, 16'h0006);
		op(5'h09, 8'h00, 1'b0, 8'h06, 16'h0000, 16'h0000, 16'h0006);
		op(5'h06, 8'h00, 1'b0, 8'h00, 16'h0000, 16'h0000, 16'h0006);
		op(5'h00, 8'h00, 1'b0, 8'h03, 16'h0001, 16'h0000, 16'h0006);
		op(5'h03, 8'h00, 1'b0, 8'h80, 16'h0002, 16'h0000, 16'h0006);
		op(5'h01, 8'h00, 1'b0, 8'hFE, 16'h0000, 16'h0000, 16'h0006);
		op(5'h0D, 8'h00, 1'b0, 8'h00, 16'h0000, 16'h0001, 16'h0006);
		op(5'h0B, 8'h00, 1'b0, 8'h01, 16'h0000, 16'h0001, 16'h0006);
		op(5'h07, 8'h00, 1'b0, 8'h00, 16'h0000, 16'h0001, 16'h0006);
		op(5'h0C, 8'h00, 1'b0, 8'h03, 16'h0003, 16'h0001, 16'h0006);
		op(5'h04, 8'h00, 1'b0, 8'h00, 16'h0001, 16'h0001, 16'h0006);
		op(5'h0E, 8'h00, 1'b0, 8'h80, 16'h0001, 16'h0001, 16'h0080);
		op(5'h11, 8'h00, 1'b0, 8'h80, 16'h0001, 16'h0001, 16'h8080);
		op(5'h12, 8'h40, 1'b1, 8'h40, 16'h0040, 16'h0001, 16'h8080);
		op(5'h08, 8'h00, 1'b0, 8'h00, 16'h0000, 16'h0040, 16'h8080);
		op(5'h14, 8'h12, 1'b1, 8'h12, 16'h1200, 16'h0040, 16'h8080);
		@(posedge ref_clk);
		irq_event <= 1'b1;
		op(5'h10, 8'h00, 1'b0, 8'h00, 16'h1200, 16'h0040, 16'h8080);
		chk({15'h0000, irq_pending}, 16'h0001);
		chk({15'h0000, irq_seen}, 16'h0001);
		op(5'h0F, 8'h00, 1'b0, 8'h00, 16'h1200, 16'h1200, 16'h8080);
		op(5'h13, 8'h00, 1'b0, 8'h00, 16'h0000, 16'h1200, 16'h8080);
		chk({15'h0000, irq_pending}, 16'h0000);
		@(posedge ref_clk);
		irq_event <= 1'b0;
		op(5'h15, 8'h34, 1'b1, 8'h34, 16'h0000, 16'h3400, 16'h8080);
		op(5'h02, 8'h00, 1'b0, 8'h00, 16'h0000, 16'h3400, 16'h8081);
		op(5'h16, 8'h55, 1'b1, 8'h55, 16'h0000, 16'h3400, 16'h8081);
		wrap_up();
	end
endmodule : tb_bus_command_decoder
